/* src/npstat_pkg.sv */
package npstat_pkg;

  // register byte addresses (all printed offsets are word aligned)
  localparam logic [7:0]  NPTX_OFFSET      = 8'h9c;
  localparam logic [7:0]  STATUS_OFFSET    = 8'hc0;
  localparam logic [7:0]  RXERR_CNT_OFFSET = 8'hd4;
  localparam logic [7:0]  FCAR_CNT_OFFSET  = 8'hd0;
  localparam logic [7:0]  TENBASE_OFFSET   = 8'h88;
  localparam logic [7:0]  ANEXP_OFFSET     = 8'h98;
  localparam logic [7:0]  INT_STAT_OFFSET  = 8'he0;
  localparam logic [7:0]  INT_MASK_OFFSET  = 8'he4;

  // reset values
  localparam logic [15:0] NPTX_RESET       = 16'h2001;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [10:0] CODE_RESET       = 11'h001;

  // next-page word fields
  localparam int NP_REQ_BIT   = 15;
  localparam int NP_RSV_BIT   = 14;
  localparam int NP_MSG_BIT   = 13;
  localparam int NP_ACK_BIT   = 12;
  localparam int NP_TOG_BIT   = 11;

  // status word fields
  localparam int ST_RXERR_BIT = 13;
  localparam int ST_POL_BIT   = 12;
  localparam int ST_FCAR_BIT  = 11;
  localparam int ST_SIG_BIT   = 10;
  localparam int ST_LOCK_BIT  = 9;
  localparam int ST_PAGE_BIT  = 8;
  localparam int ST_INT_BIT   = 7;

  // interrupt status bit positions
  localparam int EV_RXERR     = 0;
  localparam int EV_FCAR      = 1;
  localparam int EV_PAGE      = 2;
  localparam int EV_SIGLOSS   = 3;
  localparam int EV_LOCKLOSS  = 4;
  localparam int EV_COUNT     = 5;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  // live event and level indications from the phy
  typedef struct packed {
    logic rx_error;
    logic false_carrier;
    logic signal_detect;
    logic descr_lock;
    logic page_received;
    logic polarity_inv;
    logic phy_int;
    logic toggle_prev;
  } phy_ind_type;

endpackage : npstat_pkg

/* src/phy_nextpage_status_regs.sv */
`timescale 1ns/100ps
// What this block does
// [RL1] bit15 requests another next page, resets 0
// [RL2] bit14 reserved, writes ignored, reads 0
// [RL3] bit13 message page flag, resets 1
// [RL4] bit12 comply ack, resets 0
// [RL5] bit11 read-only inverse of previous toggle
// [RL6] bits10:0 code field of next page
// [RL7] code resets to null page, word 2001
// [RL8] status register read-only, resets zero
// [RL9] status bits15:14 reserved, read zero
// [RL10] bit13 receive error latched until counter read
// [RL11] bit12 inverted polarity latched high, cleared by 10base read
// [RL12] bit11 false carrier latched until counter read
// [RL13] bit10 signal detect, latched low
// [RL14] bit9 descrambler lock, latched low
// [RL15] bit8 page received, cleared by expansion read
// [RL16] bit7 interrupt pending, cleared by status read
// [RL17] latched bits hold until their clearing read
module phy_nextpage_status_regs
  import npstat_pkg::*;
(
  input  wire logic        clk_in,          // 250 MHz device clock
  input  wire logic        rst_in,          // async hard reset, active high
  input  wire logic [7:0]  addr_in,         // register byte address
  input  wire logic [31:0] wdata_in,        // write data
  input  wire logic        wr_in,           // write strobe
  input  wire logic        rd_in,           // read strobe
  input  wire logic        rx_error_in,     // receive error event pulse
  input  wire logic        false_carrier_in,// false carrier event pulse
  input  wire logic        signal_detect_in,// live 100tx signal detect
  input  wire logic        descr_lock_in,   // live descrambler lock
  input  wire logic        page_received_in,// new link code word pulse
  input  wire logic        polarity_inv_in, // live inverted polarity level
  input  wire logic        phy_int_in,      // internal phy interrupt event
  input  wire logic        toggle_prev_in,  // toggle of last exchanged word
  input  wire logic        toggle_load_in,  // pulse: a link code word exchanged
  output logic      [31:0] rdata_out,       // read data, cycle after read
  output logic      [15:0] next_page_out,   // next-page word for the arbiter
  output logic             irq_out          // level interrupt
);

  bus_req_type req;                          // bundled bus request
  phy_ind_type ind;                          // bundled phy indications

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign ind = '{rx_error: rx_error_in, false_carrier: false_carrier_in,
                 signal_detect: signal_detect_in, descr_lock: descr_lock_in,
                 page_received: page_received_in, polarity_inv: polarity_inv_in,
                 phy_int: phy_int_in, toggle_prev: toggle_prev_in};

  // next-page register state
  logic        np_req_r, np_req_nxt;         // another page request
  logic        msg_r, msg_nxt;               // message page flag
  logic        ack_r, ack_nxt;               // comply ack
  logic        tog_r, tog_nxt;               // toggle echo
  logic [10:0] code_r, code_nxt;             // code field

  // status latches
  logic        rxerr_r, rxerr_nxt;           // receive error latch
  logic        pol_r, pol_nxt;               // polarity latch
  logic        fcar_r, fcar_nxt;             // false carrier latch
  logic        sig_r, sig_nxt;               // signal detect latched low
  logic        lock_r, lock_nxt;             // descrambler lock latched low
  logic        page_r, page_nxt;             // page received latch
  logic        pint_r, pint_nxt;             // interrupt pending latch

  // interrupt registers
  logic [EV_COUNT-1:0] ist_r, ist_nxt;       // sticky event status
  logic [EV_COUNT-1:0] imask_r, imask_nxt;   // event enables
  logic [EV_COUNT-1:0] ev;                   // event pulses this cycle

  // read data
  logic [31:0] rdata_r, rdata_nxt;

  // decoded accesses
  logic wr_np, wr_ist, wr_imask;
  logic rd_st, rd_rxc, rd_fcc, rd_tb, rd_ane;
  logic [15:0] np_word, st_word;

  // address decode
  always_comb begin
    wr_np    = req.wr && (req.addr == NPTX_OFFSET);
    wr_ist   = req.wr && (req.addr == INT_STAT_OFFSET);
    wr_imask = req.wr && (req.addr == INT_MASK_OFFSET);
    rd_st    = req.rd && (req.addr == STATUS_OFFSET);
    rd_rxc   = req.rd && (req.addr == RXERR_CNT_OFFSET);
    rd_fcc   = req.rd && (req.addr == FCAR_CNT_OFFSET);
    rd_tb    = req.rd && (req.addr == TENBASE_OFFSET);
    rd_ane   = req.rd && (req.addr == ANEXP_OFFSET);
  end

  // assembled register words
  always_comb begin
    np_word             = 16'h0000;
    np_word[NP_REQ_BIT] = np_req_r;           // RL1
    np_word[NP_RSV_BIT] = 1'b0;               // RL2
    np_word[NP_MSG_BIT] = msg_r;              // RL3
    np_word[NP_ACK_BIT] = ack_r;              // RL4
    np_word[NP_TOG_BIT] = tog_r;              // RL5
    np_word[10:0]       = code_r;             // RL6
    st_word               = STATUS_RESET;     // RL9
    st_word[ST_RXERR_BIT] = rxerr_r;
    st_word[ST_POL_BIT]   = pol_r;
    st_word[ST_FCAR_BIT]  = fcar_r;
    st_word[ST_SIG_BIT]   = sig_r;
    st_word[ST_LOCK_BIT]  = lock_r;
    st_word[ST_PAGE_BIT]  = page_r;
    st_word[ST_INT_BIT]   = pint_r;
  end

  // next-page register next state; bit 14 is never stored
  always_comb begin
    np_req_nxt = np_req_r;
    msg_nxt    = msg_r;
    ack_nxt    = ack_r;
    code_nxt   = code_r;
    tog_nxt    = tog_r;
    if (wr_np) begin
      np_req_nxt = req.wdata[NP_REQ_BIT];     // RL1
      msg_nxt    = req.wdata[NP_MSG_BIT];     // RL3
      ack_nxt    = req.wdata[NP_ACK_BIT];     // RL4
      code_nxt   = req.wdata[10:0];           // RL6
    end
    // toggle is hardware-owned; software writes to it are dropped
    if (toggle_load_in) begin
      tog_nxt = ~ind.toggle_prev;             // RL5
    end
  end

  // next-page register flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      np_req_r <= NPTX_RESET[NP_REQ_BIT];     // RL1
      msg_r    <= NPTX_RESET[NP_MSG_BIT];     // RL3
      ack_r    <= NPTX_RESET[NP_ACK_BIT];     // RL4
      tog_r    <= NPTX_RESET[NP_TOG_BIT];     // RL5
      code_r   <= CODE_RESET;                 // RL7
    end else begin
      np_req_r <= np_req_nxt;
      msg_r    <= msg_nxt;
      ack_r    <= ack_nxt;
      tog_r    <= tog_nxt;
      code_r   <= code_nxt;
    end
  end

  // status latches: an event in the clearing cycle wins over the clear.
  // the status word is never written; writes to it fall through (RL8)
  always_comb begin
    rxerr_nxt = ind.rx_error | (rxerr_r & ~rd_rxc);            // RL10
    pol_nxt   = ind.polarity_inv | (pol_r & ~rd_tb);           // RL11
    fcar_nxt  = ind.false_carrier | (fcar_r & ~rd_fcc);        // RL12
    // latched low: a drop sticks at zero until the status read
    sig_nxt   = rd_st ? ind.signal_detect : (sig_r & ind.signal_detect); // RL13
    lock_nxt  = rd_st ? ind.descr_lock : (lock_r & ind.descr_lock);      // RL14
    page_nxt  = ind.page_received | (page_r & ~rd_ane);        // RL15
    pint_nxt  = ind.phy_int | (pint_r & ~rd_st);               // RL16
  end

  // status latch flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rxerr_r <= 1'b0;                         // RL8
      pol_r   <= 1'b0;
      fcar_r  <= 1'b0;
      sig_r   <= 1'b0;
      lock_r  <= 1'b0;
      page_r  <= 1'b0;
      pint_r  <= 1'b0;
    end else begin
      rxerr_r <= rxerr_nxt;                    // RL17
      pol_r   <= pol_nxt;
      fcar_r  <= fcar_nxt;
      sig_r   <= sig_nxt;
      lock_r  <= lock_nxt;
      page_r  <= page_nxt;
      pint_r  <= pint_nxt;
    end
  end

  // event sources feeding the sticky interrupt status
  always_comb begin
    ev              = '0;
    ev[EV_RXERR]    = ind.rx_error;
    ev[EV_FCAR]     = ind.false_carrier;
    ev[EV_PAGE]     = ind.page_received;
    ev[EV_SIGLOSS]  = sig_r & ~ind.signal_detect;
    ev[EV_LOCKLOSS] = lock_r & ~ind.descr_lock;
  end

  // interrupt status is write-one-to-clear; a new event beats the clear
  always_comb begin
    ist_nxt   = ist_r;
    imask_nxt = imask_r;
    if (wr_ist) begin
      ist_nxt = ist_r & ~req.wdata[EV_COUNT-1:0];
    end
    ist_nxt = ist_nxt | ev;
    if (wr_imask) begin
      imask_nxt = req.wdata[EV_COUNT-1:0];
    end
  end

  // interrupt flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ist_r   <= '0;
      imask_r <= '0;
    end else begin
      ist_r   <= ist_nxt;
      imask_r <= imask_nxt;
    end
  end

  assign irq_out = |(ist_r & imask_r);

  // read mux; unmapped and non-read cycles return zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.addr)
        NPTX_OFFSET:     rdata_nxt = {16'h0000, np_word};
        STATUS_OFFSET:   rdata_nxt = {16'h0000, st_word};   // RL8
        INT_STAT_OFFSET: rdata_nxt = {27'h0000000, ist_r};
        INT_MASK_OFFSET: rdata_nxt = {27'h0000000, imask_r};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out     = rdata_r;
  assign next_page_out = np_word;

  // assertions
  // multi-step checks other than rxerr_hold_a are built from these named request sequences so
  // that the read side effects and the returned word are tied together

  // a read of the status word in this cycle
  sequence st_read_s;
    rd_st;
  endsequence

  // a read of the next-page word in this cycle
  sequence np_read_s;
    req.rd && (req.addr == NPTX_OFFSET);
  endsequence

  // a write of the next-page word in this cycle
  sequence np_write_s;
    wr_np;
  endsequence

  // reserved next-page bit always reads zero
  np_reserved_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL2
    np_read_s |=> rdata_out[NP_RSV_BIT] == 1'b0)
    else $error("reserved next-page bit read nonzero");

  // request bit and code field land on a write
  np_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL1
    np_write_s |=> next_page_out[NP_REQ_BIT] == $past(wdata_in[NP_REQ_BIT])
      && next_page_out[10:0] == $past(wdata_in[10:0]))
    else $error("next-page write not stored");

  // a written one never reaches the reserved bit
  np_rsv_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL2
    np_write_s |=> next_page_out[NP_RSV_BIT] == 1'b0)
    else $error("reserved next-page bit stored");

  // message page flag follows the write
  np_msg_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL3
    np_write_s |=> next_page_out[NP_MSG_BIT] == $past(wdata_in[NP_MSG_BIT]))
    else $error("message page flag not stored");

  // comply ack follows the write
  np_ack_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL4
    np_write_s |=> next_page_out[NP_ACK_BIT] == $past(wdata_in[NP_ACK_BIT]))
    else $error("comply ack not stored");

  // toggle echo is the inverse of the exchanged toggle
  toggle_inv_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL5
    toggle_load_in |=> next_page_out[NP_TOG_BIT] == !$past(toggle_prev_in))
    else $error("toggle echo not inverse");

  // software cannot move the toggle echo
  toggle_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL5
    !toggle_load_in |=> $stable(next_page_out[NP_TOG_BIT]))
    else $error("toggle echo moved without exchange");

  // a next-page read returns the stored word
  np_read_word_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL6
    np_read_s |=> rdata_out == {16'h0000, $past(next_page_out)})
    else $error("next-page read word wrong");

  // a status read returns the latched word of the read cycle
  st_read_word_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL8
    st_read_s |=> rdata_out == {16'h0000, $past(st_word)})
    else $error("status read word wrong");

  // read data stand only after a read strobe
  rdata_idle_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL8
    !req.rd |=> rdata_out == 32'h0000_0000)
    else $error("read data without read");

  // reserved status bits read zero
  st_reserved_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL9
    st_read_s |=> rdata_out[15:14] == 2'b00)
    else $error("reserved status bits nonzero");

  // receive error latch survives one quiet cycle after the event
  rxerr_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL10
    rx_error_in ##1 !rd_rxc[*2] |-> rxerr_r)
    else $error("receive error latch lost");

  // counter read clears the receive error latch
  rxerr_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL10
    rd_rxc && !rx_error_in |=> !rxerr_r)
    else $error("receive error latch not cleared");

  // false carrier latches high
  fcar_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL12
    false_carrier_in |=> fcar_r)
    else $error("false carrier latch missing");

  // counter read clears the false carrier latch
  fcar_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL12
    rd_fcc && !false_carrier_in |=> !fcar_r)
    else $error("false carrier latch not cleared");

  // a drop of signal detect sticks until a status read
  sig_low_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL13
    !signal_detect_in && !rd_st |=> !sig_r)
    else $error("signal detect not latched low");

  // a status read rearms signal detect from the live level
  sig_rearm_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL13
    st_read_s ##0 signal_detect_in |=> sig_r)
    else $error("signal detect not rearmed");

  // a loss of lock sticks until a status read
  lock_low_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL14
    !descr_lock_in && !rd_st |=> !lock_r)
    else $error("lock not latched low");

  // a status read rearms lock from the live level
  lock_rearm_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL14
    st_read_s ##0 descr_lock_in |=> lock_r)
    else $error("lock not rearmed");

  // page flag survives a status read
  page_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL15
    st_read_s ##0 (!rd_ane && page_r) |=> page_r)
    else $error("page flag cleared by status read");

  // a new link code word sets the page flag
  page_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL15
    page_received_in |=> page_r)
    else $error("page flag not set");

  // the read that returns the pending bit clears it
  int_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL16
    st_read_s ##0 !phy_int_in |=> !pint_r ##0 rdata_out[ST_INT_BIT] == $past(pint_r))
    else $error("interrupt pending not cleared by read");

  // an internal interrupt sets the pending bit
  int_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL16
    phy_int_in |=> pint_r)
    else $error("interrupt pending not set");

  // ten-base status read clears the polarity latch
  pol_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL11
    rd_tb && !polarity_inv_in |=> !pol_r)
    else $error("polarity latch not cleared");

  // inverted polarity sets the latch
  pol_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL11
    polarity_inv_in |=> pol_r)
    else $error("polarity latch not set");

endmodule : phy_nextpage_status_regs

/* bench/link_partner_model.sv */
`timescale 1ns/100ps
// far end of the next-page exchange: answers a sent page after a chosen delay
module link_partner_model
  import npstat_pkg::*;
(
  input  wire logic       clk_in,            // device clock
  input  wire logic       rst_in,            // async reset, active high
  input  wire logic       send_in,           // pulse: local page sent
  input  wire logic [3:0] delay_in,          // answer delay in cycles, 0 = prompt
  input  wire logic       tog_in,            // toggle carried by the exchanged word
  output logic            page_received_out, // pulse: link code word arrived
  output logic            toggle_load_out,   // pulse: word exchanged
  output logic            toggle_prev_out    // toggle of that word
);
  logic [4:0] cnt_r;    // cycles left until the answer
  logic       pulse_r;  // one-cycle answer strobe
  logic       tog_r;    // toggle of the word in flight
  // answer counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r   <= 5'h00;
      pulse_r <= 1'b0;
      tog_r   <= 1'b0;
    end else begin
      pulse_r <= (cnt_r == 5'h01);
      if (send_in) begin
        cnt_r <= {1'b0, delay_in} + 5'h01;
        tog_r <= tog_in;
      end else if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end
  assign page_received_out = pulse_r;
  assign toggle_load_out   = pulse_r;
  // outside the strobe the toggle level is not held, so the inverse of the word's toggle shows
  assign toggle_prev_out   = pulse_r ? tog_r : ~tog_r;
endmodule : link_partner_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
// register bench: bus driver notes expectations, monitor compares read data
module tb_top
  import npstat_pkg::*;
;
  logic        clk_in = 1'b0;            // 250 MHz clock
  logic        rst_in = 1'b1;            // async reset
  logic [7:0]  addr = 8'h00;             // bus address
  logic [31:0] wdata = 32'h0;            // bus write data
  logic        wr = 1'b0, rd = 1'b0;     // bus strobes
  phy_ind_type ind = 8'h30;              // live levels: detect and lock up
  logic        send = 1'b0, tog = 1'b0;  // partner request
  logic [3:0]  dly = 4'h0;               // partner answer delay
  logic        pg, tld, tprev;           // partner outputs
  logic [31:0] rdata_out;
  logic [15:0] next_page_out;
  logic        irq_out;
  logic [16:0] exp_q[$];                 // {care, value} per read
  logic [16:0] note;
  logic        rd_seen = 1'b0;           // read strobe one cycle late
  logic [31:0] seed = 32'hf2a7ab7e;
  logic [15:0] v;                        // next-page word expected back after the last write
  int          err_count = 0, checks = 0;
  always #2 clk_in = ~clk_in;
  phy_nextpage_status_regs uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rx_error_in(ind.rx_error),
    .false_carrier_in(ind.false_carrier), .signal_detect_in(ind.signal_detect),
    .descr_lock_in(ind.descr_lock), .page_received_in(pg),
    .polarity_inv_in(ind.polarity_inv), .phy_int_in(ind.phy_int),
    .toggle_prev_in(tprev), .toggle_load_in(tld), .rdata_out(rdata_out),
    .next_page_out(next_page_out), .irq_out(irq_out));
  link_partner_model lp (.clk_in(clk_in), .rst_in(rst_in), .send_in(send),
    .delay_in(dly), .tog_in(tog), .page_received_out(pg), .toggle_load_out(tld),
    .toggle_prev_out(tprev));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= {16'h0, d};
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : bus_wr
  // care low: read only for its side effect, data not compared
  task automatic bus_rd(input logic [7:0] a, input logic [15:0] e, input logic care);
    exp_q.push_back({care, e});
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
  endtask : bus_rd
  // flip chosen indications for exactly one cycle
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_in);
    ind <= ind ^ m;
    @(posedge clk_in);
    ind <= ind ^ m;
  endtask : pulse
  task automatic xchg(input logic t, input logic [3:0] d);
    @(posedge clk_in);
    send <= 1'b1;
    tog  <= t;
    dly  <= d;
    @(posedge clk_in);
    send <= 1'b0;
    for (int i = 0; i < 40 && !pg; i++) @(posedge clk_in);
    @(posedge clk_in);
  endtask : xchg
  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (rd_seen) begin
      note = exp_q.pop_front();
      if (note[16]) chk("rdata", {16'h0, note[15:0]}, rdata_out);
    end
    rd_seen <= rd;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0]  lh_m[3] = '{8'h80, 8'h40, 8'h04};
    logic [15:0] lh_b[3] = '{16'h2000, 16'h0800, 16'h1000};
    logic [7:0]  lh_a[3] = '{8'hd4, 8'hd0, 8'h88};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    bus_rd(NPTX_OFFSET, 16'h2001, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0000, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    bus_wr(STATUS_OFFSET, 16'hffff);
    bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    bus_rd(8'h10, 16'h0000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = seed[15:0] & 16'hb7ff;
      bus_wr(NPTX_OFFSET, seed[15:0]);
      bus_rd(NPTX_OFFSET, v, 1'b1);
      #1 chk("next_page", {16'h0, v}, {16'h0, next_page_out});
    end
    xchg(1'b0, 4'h3);
    bus_rd(NPTX_OFFSET, v | 16'h0800, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0700, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0700, 1'b1);
    bus_rd(ANEXP_OFFSET, 16'h0000, 1'b0);
    bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    xchg(1'b1, 4'h0);
    bus_rd(NPTX_OFFSET, v, 1'b1);
    bus_rd(ANEXP_OFFSET, 16'h0000, 1'b0);
    for (int i = 0; i < 3; i++) begin
      pulse(lh_m[i]);
      bus_rd(STATUS_OFFSET, 16'h0600 | lh_b[i], 1'b1);
      bus_rd(STATUS_OFFSET, 16'h0600 | lh_b[i], 1'b1);
      bus_rd(lh_a[i], 16'h0000, 1'b0);
      bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    end
    pulse(8'h02);
    bus_rd(STATUS_OFFSET, 16'h0680, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    pulse(8'h20);
    bus_rd(STATUS_OFFSET, 16'h0200, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    pulse(8'h10);
    bus_rd(STATUS_OFFSET, 16'h0400, 1'b1);
    bus_rd(STATUS_OFFSET, 16'h0600, 1'b1);
    // every event fired at least once (page twice), all masked so far
    bus_rd(INT_STAT_OFFSET, 16'h001f, 1'b1);
    #1 chk("irq", 32'h0, {31'h0, irq_out});
    bus_wr(INT_MASK_OFFSET, 16'h0002);
    repeat (2) @(posedge clk_in);
    #1 chk("irq", 32'h1, {31'h0, irq_out});
    bus_wr(INT_STAT_OFFSET, 16'h001d);
    bus_rd(INT_STAT_OFFSET, 16'h0002, 1'b1);
    bus_rd(INT_MASK_OFFSET, 16'h0002, 1'b1);
    #1 chk("irq", 32'h1, {31'h0, irq_out});
    bus_wr(INT_STAT_OFFSET, 16'h0002);
    repeat (2) @(posedge clk_in);
    #1 chk("irq", 32'h0, {31'h0, irq_out});
    repeat (4) @(posedge clk_in);
    tally_and_finish();
  end
endmodule : tb_top
